// ===== rtl/ext_bus_pkg.sv
package ext_bus_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_BUS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PULLUP = 8'h04;
	localparam logic [7:0] OFS_CONFIG = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	// bus_control_reg fields
	localparam int BUS_DISABLE_BIT = 7;
	localparam int WAIT_LSB = 4;
	localparam int WM_LSB = 0;
	localparam logic [7:0] BUS_CTRL_WMASK = 8'hB3;
	localparam logic [7:0] BUS_CTRL_RST = 8'h00;
	// Pull-up control fields
	localparam int PU_LOW_BIT = 7;
	localparam int PU_HIGH_BIT = 6;
	localparam int PU_CTRL_BIT = 5;
	localparam logic [7:0] PULLUP_WMASK = 8'hE0;
	localparam logic [7:0] PULLUP_RST = 8'h00;
	// Configuration fields
	localparam int CFG_SHIFT_BIT = 0;
	localparam int CFG_WAIT_EN_BIT = 1;
	localparam int CFG_WIDE_BIT = 2;
	localparam int CFG_AW_LSB = 4;
	localparam logic [7:0] CFG_WMASK = 8'h37;
	localparam logic [7:0] CONFIG_RST = 8'h04;
	// Status fields
	localparam int ST_OWNS_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_DIS_EFF_BIT = 2;
	localparam int ST_EXEC_EXT_BIT = 3;
	// Address width / program memory mode
	localparam logic [1:0] AW_SINGLE = 2'b00;
	localparam logic [1:0] AW_16 = 2'b01;
	localparam logic [1:0] AW_12 = 2'b10;
	localparam logic [1:0] AW_20 = 2'b11;
	localparam logic [19:0] MASK_12 = 20'h00FFF;
	localparam logic [19:0] MASK_16 = 20'h0FFFF;
	localparam logic [19:0] MASK_20 = 20'hFFFFF;
	// Write modes and wait encoding
	localparam logic [1:0] WM_BYTE_WRITE = 2'b00;
	localparam logic [1:0] WM_BYTE_SELECT = 2'b01;
	localparam logic [1:0] WAIT_NONE = 2'b11;
	// Request kinds
	localparam logic [1:0] KIND_FETCH = 2'h0;
	localparam logic [1:0] KIND_READ = 2'h1;
	localparam logic [1:0] KIND_WRITE = 2'h2;
	// Timing and AHB transfer size
	localparam int CLK_PERIOD_NS = 10;
	localparam int TCY_NS = 40;
	localparam int TCY_CLKS = TCY_NS / CLK_PERIOD_NS;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ===== rtl/ext_mem_bus.sv
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ext_mem_bus #(
	parameter int CLKS_PER_TCY = ext_bus_pkg::TCY_CLKS,
	parameter logic [20:0] INT_MEM_BYTES = 21'h020000
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Core request side
	input wire logic REQ_VALID,
	input wire logic [1:0] REQ_KIND,
	input wire logic [20:0] REQ_ADDR,
	input wire logic [7:0] REQ_TABLE_LATCH,
	input wire logic EXEC_EXTERNAL,
	input wire logic SLEEP,
	output logic REQ_READY,
	output logic REQ_DONE,
	output logic [15:0] REQ_RDATA,
	// Address/data and upper address pins
	input wire logic [15:0] AD_IN,
	output logic [15:0] AD_OUT,
	output logic [15:0] AD_OE_N,
	output logic [3:0] UPPER_ADDR_OUT,
	output logic [3:0] UPPER_ADDR_OE_N,
	// Control pins
	output logic ALE,
	output logic OUTPUT_ENABLE_N,
	output logic WRITE_LOW_N,
	output logic WRITE_HIGH_N,
	output logic BYTE_ADDRESS_LSB,
	output logic CHIP_SELECT_N,
	output logic LOWER_BYTE_SELECT_N,
	output logic UPPER_BYTE_SELECT_N,
	// Pin ownership and pull-ups towards the port logic
	output logic [19:0] BUS_OWNS_ADDR_PINS,
	output logic BUS_OWNS_CTRL_PINS,
	output logic LOW_BUS_PORT_PULLUP_EN,
	output logic HIGH_BUS_PORT_PULLUP_EN,
	output logic CONTROL_PORT_PULLUP_EN
);
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_WAIT, ST_DONE} state_e;

	state_e state_reg;
	logic [7:0] bus_control_reg, pullup_reg, config_reg;
	logic [7:0] ahb_addr_reg;
	logic ahb_wr_reg;
	logic [31:0] rd_value;
	logic [$clog2(CLKS_PER_TCY+1)-1:0] div_reg;
	logic tick;
	logic [1:0] kind_reg;
	logic [20:0] addr_reg, bus_addr;
	logic [7:0] latch_reg, holding_reg;
	logic [1:0] wait_left_reg;
	logic dis_eff_reg;
	logic [15:0] sync1_reg, sync2_reg, sync3_reg, ad_filt_reg, ad_agree;
	logic ext_mode, wide, owns;
	logic [1:0] aw, wm;
	logic [19:0] aw_mask;
	logic is_write, word_write;

	function automatic logic [19:0] width_mask(input logic [1:0] mode);
		case (mode)
			ext_bus_pkg::AW_12: width_mask = ext_bus_pkg::MASK_12;
			ext_bus_pkg::AW_16: width_mask = ext_bus_pkg::MASK_16;
			ext_bus_pkg::AW_20: width_mask = ext_bus_pkg::MASK_20;
			default: width_mask = '0;
		endcase
	endfunction

	assign aw = config_reg[ext_bus_pkg::CFG_AW_LSB +: 2];
	assign wide = config_reg[ext_bus_pkg::CFG_WIDE_BIT];
	assign wm = bus_control_reg[ext_bus_pkg::WM_LSB +: 2];
	assign ext_mode = (aw != ext_bus_pkg::AW_SINGLE);
	assign aw_mask = width_mask(aw);
	assign is_write = (kind_reg == ext_bus_pkg::KIND_WRITE);
	assign word_write = wide && wm[1];
	// Bus holds pins while accessing or when not disabled; never in single-chip
	assign owns = ext_mode && (state_reg != ST_IDLE || !dis_eff_reg);
	// Shift so the first external location appears at zero
	assign bus_addr = config_reg[ext_bus_pkg::CFG_SHIFT_BIT] ? addr_reg - INT_MEM_BYTES
		: addr_reg;
	assign tick = (div_reg == '0);
	// A pad bit is taken once the last two stages agree
	assign ad_agree = (sync3_reg & ~(sync2_reg ^ sync3_reg))
		| (ad_filt_reg & (sync2_reg ^ sync3_reg));

	// AHB-Lite address phase capture; single cycle answer, always OKAY
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ahb_addr_reg <= '0;
			ahb_wr_reg <= 1'b0;
			HREADYOUT <= 1'b0;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			if (HREADY) begin
				ahb_addr_reg <= HADDR[7:0];
				ahb_wr_reg <= HSEL && HTRANS[1] && HWRITE && HSIZE == ext_bus_pkg::HSIZE_WORD;
			end
		end
	end

	always_comb begin
		rd_value = '0;
		case (HADDR[7:0])
			ext_bus_pkg::OFS_BUS_CTRL: rd_value[7:0] = bus_control_reg;
			ext_bus_pkg::OFS_PULLUP: rd_value[7:0] = pullup_reg;
			ext_bus_pkg::OFS_CONFIG: rd_value[7:0] = config_reg;
			ext_bus_pkg::OFS_STATUS: begin
				rd_value[ext_bus_pkg::ST_OWNS_BIT] = owns;
				rd_value[ext_bus_pkg::ST_BUSY_BIT] = (state_reg != ST_IDLE);
				rd_value[ext_bus_pkg::ST_DIS_EFF_BIT] = dis_eff_reg;
				rd_value[ext_bus_pkg::ST_EXEC_EXT_BIT] = EXEC_EXTERNAL;
			end
			default: rd_value = '0;
		endcase
	end

	// Registered at the address phase so it stands for the whole data phase
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			HRDATA <= '0;
		end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
			HRDATA <= rd_value;
		end
	end

	// Register writes
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			bus_control_reg <= ext_bus_pkg::BUS_CTRL_RST;
			pullup_reg <= ext_bus_pkg::PULLUP_RST;
			config_reg <= ext_bus_pkg::CONFIG_RST;
		end else if (ahb_wr_reg) begin
			case (ahb_addr_reg)
				ext_bus_pkg::OFS_BUS_CTRL: begin
					if (ext_mode) begin
						bus_control_reg <= HWDATA[7:0] & ext_bus_pkg::BUS_CTRL_WMASK;
					end
				end
				ext_bus_pkg::OFS_PULLUP: pullup_reg <= HWDATA[7:0] & ext_bus_pkg::PULLUP_WMASK;
				ext_bus_pkg::OFS_CONFIG: config_reg <= HWDATA[7:0] & ext_bus_pkg::CFG_WMASK;
				default: ;
			endcase
		end
	end

	// Pull-up enables towards the port pads
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			LOW_BUS_PORT_PULLUP_EN <= 1'b0;
			HIGH_BUS_PORT_PULLUP_EN <= 1'b0;
			CONTROL_PORT_PULLUP_EN <= 1'b0;
		end else begin
			LOW_BUS_PORT_PULLUP_EN <= pullup_reg[ext_bus_pkg::PU_LOW_BIT];
			HIGH_BUS_PORT_PULLUP_EN <= pullup_reg[ext_bus_pkg::PU_HIGH_BIT];
			CONTROL_PORT_PULLUP_EN <= pullup_reg[ext_bus_pkg::PU_CTRL_BIT];
		end
	end

	// Disable takes effect only once execution is back in internal memory
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dis_eff_reg <= 1'b0;
		end else if (!EXEC_EXTERNAL) begin
			dis_eff_reg <= bus_control_reg[ext_bus_pkg::BUS_DISABLE_BIT];
		end
	end

	// Instruction cycle enable
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_reg <= '0;
		end else if (tick) begin
			div_reg <= ($clog2(CLKS_PER_TCY+1))'(CLKS_PER_TCY - 1);
		end else begin
			div_reg <= div_reg - 1'b1;
		end
	end

	// Pad inputs: three stages, value taken once the last two agree
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			ad_filt_reg <= '0;
		end else begin
			sync1_reg <= AD_IN;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			ad_filt_reg <= ad_agree;
		end
	end

	// Access sequencer: address phase runs to the next tick, data and each wait phase one instruction cycle
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg <= ST_IDLE;
			kind_reg <= ext_bus_pkg::KIND_FETCH;
			addr_reg <= '0;
			latch_reg <= '0;
			holding_reg <= '0;
			wait_left_reg <= '0;
			REQ_READY <= 1'b0;
			REQ_DONE <= 1'b0;
			REQ_RDATA <= '0;
		end else begin
			REQ_DONE <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					REQ_READY <= ext_mode && !SLEEP;
					if (REQ_VALID && REQ_READY) begin
						REQ_READY <= 1'b0;
						kind_reg <= REQ_KIND;
						addr_reg <= REQ_ADDR;
						latch_reg <= REQ_TABLE_LATCH;
						state_reg <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					if (tick) begin
						// Waits follow table operations only
						if (config_reg[ext_bus_pkg::CFG_WAIT_EN_BIT]
							&& kind_reg != ext_bus_pkg::KIND_FETCH) begin
							wait_left_reg <= ext_bus_pkg::WAIT_NONE
								- bus_control_reg[ext_bus_pkg::WAIT_LSB +: 2];
						end else begin
							wait_left_reg <= '0;
						end
						state_reg <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (tick) begin
						state_reg <= (wait_left_reg != '0) ? ST_WAIT : ST_DONE;
					end
				end
				ST_WAIT: begin
					if (tick) begin
						wait_left_reg <= wait_left_reg - 1'b1;
						if (wait_left_reg == 2'd1) begin
							state_reg <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					// Even word-write half is parked for the odd half
					if (is_write && word_write && !addr_reg[0]) begin
						holding_reg <= latch_reg;
					end
					// Pads lag the strobe by three clocks; needs CLKS_PER_TCY of 4 or more
					if (!is_write) begin
						REQ_RDATA <= wide ? ad_agree : {8'h00, ad_agree[7:0]};
					end
					REQ_DONE <= 1'b1;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Pin ownership for the port multiplexers; bus overrides every other user
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			BUS_OWNS_ADDR_PINS <= '0;
			BUS_OWNS_CTRL_PINS <= 1'b0;
		end else begin
			BUS_OWNS_ADDR_PINS <= owns ? aw_mask : '0;
			BUS_OWNS_CTRL_PINS <= owns;
		end
	end

	// Pin drive, registered from the sequencer state
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			AD_OUT <= '0;
			AD_OE_N <= '1;
			UPPER_ADDR_OUT <= '0;
			UPPER_ADDR_OE_N <= '1;
			ALE <= 1'b0;
			OUTPUT_ENABLE_N <= 1'b1;
			WRITE_LOW_N <= 1'b1;
			WRITE_HIGH_N <= 1'b1;
			BYTE_ADDRESS_LSB <= 1'b0;
			CHIP_SELECT_N <= 1'b1;
			LOWER_BYTE_SELECT_N <= 1'b1;
			UPPER_BYTE_SELECT_N <= 1'b1;
		end else begin
			// Idle owned bus: data floats, strobes high, ALE and lsb low
			AD_OE_N <= '1;
			UPPER_ADDR_OE_N <= '1;
			ALE <= 1'b0;
			OUTPUT_ENABLE_N <= 1'b1;
			WRITE_LOW_N <= 1'b1;
			WRITE_HIGH_N <= 1'b1;
			BYTE_ADDRESS_LSB <= 1'b0;
			CHIP_SELECT_N <= 1'b1;
			LOWER_BYTE_SELECT_N <= 1'b1;
			UPPER_BYTE_SELECT_N <= 1'b1;
			case (state_reg)
				ST_ADDR: begin
					ALE <= 1'b1;
					CHIP_SELECT_N <= SLEEP;
					AD_OUT <= bus_addr[16:1];
					UPPER_ADDR_OUT <= bus_addr[20:17];
					AD_OE_N <= ~aw_mask[15:0];
					UPPER_ADDR_OE_N <= ~aw_mask[19:16];
					BYTE_ADDRESS_LSB <= bus_addr[0];
				end
				ST_DATA, ST_WAIT: begin
					CHIP_SELECT_N <= SLEEP;
					BYTE_ADDRESS_LSB <= bus_addr[0];
					if (!is_write) begin
						OUTPUT_ENABLE_N <= 1'b0;
						LOWER_BYTE_SELECT_N <= SLEEP;
						UPPER_BYTE_SELECT_N <= SLEEP || !wide;
					end else if (!wide) begin
						AD_OUT <= {8'h00, latch_reg};
						AD_OE_N <= {8'hFF, 8'h00};
						WRITE_LOW_N <= 1'b0;
					end else if (word_write) begin
						// Even half only loads the holding latch, bus floats
						if (addr_reg[0]) begin
							AD_OUT <= {latch_reg, holding_reg};
							AD_OE_N <= '0;
							WRITE_HIGH_N <= 1'b0;
							LOWER_BYTE_SELECT_N <= SLEEP;
							UPPER_BYTE_SELECT_N <= SLEEP;
						end
					end else begin
						AD_OUT <= {latch_reg, latch_reg};
						AD_OE_N <= '0;
						if (wm == ext_bus_pkg::WM_BYTE_SELECT) begin
							WRITE_HIGH_N <= 1'b0;
							UPPER_BYTE_SELECT_N <= SLEEP || !addr_reg[0];
							LOWER_BYTE_SELECT_N <= SLEEP || addr_reg[0];
						end else begin
							WRITE_HIGH_N <= !addr_reg[0];
							WRITE_LOW_N <= addr_reg[0];
						end
					end
				end
				default: ;
			endcase
		end
	end
endmodule

// ===== tb/ext_mem_bus_props.sv
`timescale 1ns/1ps
module ext_mem_bus_props #(
	parameter int CLKS_PER_TCY = 4
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	// Core side
	input wire logic REQ_VALID,
	input wire logic REQ_READY,
	input wire logic REQ_DONE,
	input wire logic SLEEP,
	// Bus pins, pin ownership and pull-up enables
	input wire logic [15:0] AD_OE_N,
	input wire logic ALE,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic WRITE_LOW_N,
	input wire logic WRITE_HIGH_N,
	input wire logic BYTE_ADDRESS_LSB,
	input wire logic CHIP_SELECT_N,
	input wire logic [19:0] BUS_OWNS_ADDR_PINS,
	input wire logic LOW_BUS_PORT_PULLUP_EN,
	input wire logic HIGH_BUS_PORT_PULLUP_EN,
	input wire logic CONTROL_PORT_PULLUP_EN
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_accept; REQ_VALID && REQ_READY; endsequence
	sequence s_addr; ALE && !CHIP_SELECT_N; endsequence
	a_pullup_reset:
		assert property ($rose(ARST_N) |-> !LOW_BUS_PORT_PULLUP_EN && !HIGH_BUS_PORT_PULLUP_EN
			&& !CONTROL_PORT_PULLUP_EN) else $error("pull-up left on after reset");
	a_strobe_single:
		assert property (WRITE_LOW_N || WRITE_HIGH_N) else $error("both write strobes low");
	a_idle_ctrl:
		assert property (CHIP_SELECT_N && !SLEEP |-> !ALE && OUTPUT_ENABLE_N && WRITE_LOW_N
			&& WRITE_HIGH_N && !BYTE_ADDRESS_LSB) else $error("idle control level wrong");
	a_accept_addr:
		assert property (s_accept |-> ##[1:6] s_addr) else $error("no address phase");
	a_done_bound:
		assert property (s_accept |-> ##[7:22] REQ_DONE) else $error("access too long");
	a_write_drive:
		assert property (!WRITE_LOW_N || !WRITE_HIGH_N |-> !CHIP_SELECT_N && OUTPUT_ENABLE_N
			&& AD_OE_N[7:0] == 8'h00) else $error("write without driven data");
	a_sleep_quiet:
		assert property (SLEEP && $past(SLEEP) |-> CHIP_SELECT_N && !REQ_READY)
		else $error("chip select active in sleep");
	a_drive_owned:
		assert property ((~AD_OE_N & ~BUS_OWNS_ADDR_PINS[15:0]) == 16'h0000)
		else $error("driving a line not owned");
endmodule
bind ext_mem_bus ext_mem_bus_props #(.CLKS_PER_TCY(CLKS_PER_TCY)) u_props (.SYS_CLK,
	.ARST_N, .REQ_VALID, .REQ_READY, .REQ_DONE, .SLEEP, .AD_OE_N, .ALE, .OUTPUT_ENABLE_N,
	.WRITE_LOW_N, .WRITE_HIGH_N, .BYTE_ADDRESS_LSB, .CHIP_SELECT_N, .BUS_OWNS_ADDR_PINS,
	.LOW_BUS_PORT_PULLUP_EN, .HIGH_BUS_PORT_PULLUP_EN, .CONTROL_PORT_PULLUP_EN);

// ===== tb/ext_flash_model.sv
`timescale 1ns/1ps
module ext_flash_model (
	// Bus pins from the device
	input wire logic SYS_CLK,
	input wire logic ALE,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic CHIP_SELECT_N,
	input wire logic [15:0] AD_OUT,
	input wire logic [3:0] UPPER_ADDR_OUT,
	// Data back to the pads
	output logic [15:0] AD_IN
);
	logic [19:0] word_addr = 20'h00000;
	logic [15:0] last = 16'h0000;
	always @(posedge SYS_CLK) begin
		if (ALE) begin
			word_addr <= {UPPER_ADDR_OUT, AD_OUT};
		end
		if (!OUTPUT_ENABLE_N) begin
			last <= AD_IN;
		end
	end
	// Released lines show the inverse of the last word, so stale data never passes
	always @* begin
		if (!OUTPUT_ENABLE_N && !CHIP_SELECT_N) begin
			AD_IN = word_addr[15:0] ^ {word_addr[19:16], 12'hA5C};
		end else begin
			AD_IN = ~last;
		end
	end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic SYS_CLK, ARST_N, HSEL, HWRITE, HREADYOUT, HRESP, REQ_VALID, EXEC_EXTERNAL, SLEEP;
	logic REQ_READY, REQ_DONE, ALE, OUTPUT_ENABLE_N, WRITE_LOW_N, WRITE_HIGH_N, BYTE_ADDRESS_LSB;
	logic CHIP_SELECT_N, LOWER_BYTE_SELECT_N, UPPER_BYTE_SELECT_N, BUS_OWNS_CTRL_PINS;
	logic LOW_BUS_PORT_PULLUP_EN, HIGH_BUS_PORT_PULLUP_EN, CONTROL_PORT_PULLUP_EN;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	logic [1:0] HTRANS, REQ_KIND;
	logic [2:0] HSIZE;
	logic [20:0] REQ_ADDR;
	logic [7:0] REQ_TABLE_LATCH;
	logic [15:0] REQ_RDATA, AD_IN, AD_OUT, AD_OE_N, wd;
	logic [3:0] UPPER_ADDR_OUT, UPPER_ADDR_OE_N;
	logic [19:0] BUS_OWNS_ADDR_PINS, adr;
	logic ba, wl, wh, ub, lb;
	int err_total, num_checks, cyc;
	ext_mem_bus u_ext_mem_bus (.SYS_CLK, .ARST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
		.HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .REQ_VALID, .REQ_KIND,
		.REQ_ADDR, .REQ_TABLE_LATCH, .EXEC_EXTERNAL, .SLEEP, .REQ_READY, .REQ_DONE, .REQ_RDATA,
		.AD_IN, .AD_OUT, .AD_OE_N, .UPPER_ADDR_OUT, .UPPER_ADDR_OE_N, .ALE, .OUTPUT_ENABLE_N,
		.WRITE_LOW_N, .WRITE_HIGH_N, .BYTE_ADDRESS_LSB, .CHIP_SELECT_N, .LOWER_BYTE_SELECT_N,
		.UPPER_BYTE_SELECT_N, .BUS_OWNS_ADDR_PINS, .BUS_OWNS_CTRL_PINS,
		.LOW_BUS_PORT_PULLUP_EN, .HIGH_BUS_PORT_PULLUP_EN, .CONTROL_PORT_PULLUP_EN);
	ext_flash_model u_ext_flash_model (.SYS_CLK, .ALE, .OUTPUT_ENABLE_N, .CHIP_SELECT_N,
		.AD_OUT, .UPPER_ADDR_OUT, .AD_IN);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HADDR <= {24'h000000, a};
		HWRITE <= w;
		do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'b00;
		HWDATA <= d;
		do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h00000000);
		chk(rd, e);
	endtask
	task automatic core(input logic [1:0] k, input logic [20:0] a, input logic [7:0] l);
		int t;
		@(posedge SYS_CLK);
		REQ_KIND <= k;
		REQ_ADDR <= a;
		REQ_TABLE_LATCH <= l;
		REQ_VALID <= 1'b1;
		t = 0;
		do @(negedge SYS_CLK); while (REQ_READY !== 1'b1 && t++ < 99);
		@(posedge SYS_CLK);
		REQ_VALID <= 1'b0;
		{cyc, wl, wh, ub, lb} = '0;
		while (REQ_DONE !== 1'b1 && cyc < 99) begin
			@(negedge SYS_CLK);
			cyc++;
			if (ALE) {adr, ba} = {UPPER_ADDR_OUT, AD_OUT, BYTE_ADDRESS_LSB};
			if (!WRITE_LOW_N || !WRITE_HIGH_N) wd = AD_OUT;
			wl |= !WRITE_LOW_N;
			wh |= !WRITE_HIGH_N;
			ub |= !UPPER_BYTE_SELECT_N;
			lb |= !LOWER_BYTE_SELECT_N;
		end
		if (REQ_DONE !== 1'b1) err_total++;
	endtask
	task automatic refused();
		@(posedge SYS_CLK);
		REQ_VALID <= 1'b1;
		repeat (12) @(negedge SYS_CLK);
		chk(32'({REQ_READY, CHIP_SELECT_N}), 32'h1);
		@(posedge SYS_CLK);
		REQ_VALID <= 1'b0;
	endtask
	task automatic own(input logic [19:0] e);
		repeat (3) @(negedge SYS_CLK);
		chk(32'({BUS_OWNS_CTRL_PINS, BUS_OWNS_ADDR_PINS}), 32'({|e, e}));
	endtask
	task automatic do_reset();
		ARST_N <= 1'b0;
		repeat (4) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		SYS_CLK = 1'b0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end
	// Whole run needs a few hundred cycles
	initial begin
		#500000;
		err_total++;
		results();
	end
	initial begin
		logic [20:0] a;
		logic [7:0] l0;
		logic [7:0] l1;
		{HSEL, HWRITE, REQ_VALID, EXEC_EXTERNAL, SLEEP} = '0;
		{HADDR, HWDATA, HTRANS, REQ_KIND, REQ_ADDR, REQ_TABLE_LATCH} = '0;
		HSIZE = ext_bus_pkg::HSIZE_WORD;
		void'($urandom(32'h7c07e992));
		do_reset();
		rchk(8'h08, 32'h04);
		rchk(8'h10, 32'h00);
		ahb(1'b1, 8'h00, 32'hFF);
		rchk(8'h00, 32'h00);
		refused();
		own(20'h00000);
		ahb(1'b1, 8'h04, 32'hFF);
		rchk(8'h04, 32'hE0);
		chk(32'({LOW_BUS_PORT_PULLUP_EN, HIGH_BUS_PORT_PULLUP_EN, CONTROL_PORT_PULLUP_EN}), 32'h7);
		do_reset();
		rchk(8'h04, 32'h00);
		ahb(1'b1, 8'h08, 32'h36);
		for (int w = 0; w < 4; w++) begin
			ahb(1'b1, 8'h00, 32'(w << 4));
			a = 21'h020000 + 21'($urandom % 32'h1E0000);
			core(ext_bus_pkg::KIND_READ, a, 8'h00);
			chk(32'({adr, ba}), 32'(a));
			chk(32'(REQ_RDATA), 32'(a[16:1] ^ {a[20:17], 12'hA5C}));
			chk(32'(cyc >= 19 - 4 * w && cyc <= 22 - 4 * w), 32'h1);
		end
		ahb(1'b1, 8'h00, 32'h00);
		core(ext_bus_pkg::KIND_FETCH, a, 8'h00);
		chk(32'(cyc >= 7 && cyc <= 10), 32'h1);
		ahb(1'b1, 8'h08, 32'h37);
		core(ext_bus_pkg::KIND_READ, a, 8'h00);
		chk(32'({adr, ba}), 32'(a - 21'h020000));
		for (int m = 0; m < 2; m++) begin
			ahb(1'b1, 8'h00, 32'h30 + 32'(m));
			for (int i = 0; i < 2; i++) begin
				l0 = 8'($urandom);
				core(ext_bus_pkg::KIND_WRITE, {a[20:1], 1'(i)}, l0);
				chk(32'(wd), 32'({l0, l0}));
				chk(32'({wh, wl}), (m == 1 || i == 1) ? 32'h2 : 32'h1);
				if (m == 1) chk(32'({ub, lb, ba}), i == 1 ? 32'h5 : 32'h2);
			end
		end
		ahb(1'b1, 8'h00, 32'h32);
		l0 = 8'($urandom);
		l1 = 8'($urandom);
		core(ext_bus_pkg::KIND_WRITE, {a[20:1], 1'b0}, l0);
		chk(32'({wh, wl}), 32'h0);
		core(ext_bus_pkg::KIND_WRITE, {a[20:1], 1'b1}, l1);
		chk(32'({wd, wh, wl, ub, lb}), 32'({l1, l0, 4'hB}));
		ahb(1'b1, 8'h08, 32'h36);
		ahb(1'b1, 8'h00, 32'hB0);
		own(20'h00000);
		ahb(1'b1, 8'h00, 32'h30);
		@(posedge SYS_CLK);
		EXEC_EXTERNAL <= 1'b1;
		ahb(1'b1, 8'h00, 32'hB0);
		own(20'hFFFFF);
		@(posedge SYS_CLK);
		EXEC_EXTERNAL <= 1'b0;
		own(20'h00000);
		core(ext_bus_pkg::KIND_READ, a, 8'h00);
		chk(32'({adr, ba}), 32'(a));
		ahb(1'b1, 8'h00, 32'h30);
		own(20'hFFFFF);
		chk(32'({AD_OE_N, CHIP_SELECT_N, ALE, OUTPUT_ENABLE_N, WRITE_LOW_N, WRITE_HIGH_N,
			BYTE_ADDRESS_LSB, UPPER_BYTE_SELECT_N, LOWER_BYTE_SELECT_N}), 32'h00FFFFBB);
		chk(32'({HRESP, UPPER_ADDR_OE_N}), 32'h0F);
		ahb(1'b1, 8'h08, 32'h16);
		own(20'h0FFFF);
		@(posedge SYS_CLK);
		SLEEP <= 1'b1;
		refused();
		results();
	end
endmodule
